//--- src/adcogc_top.sv
// Offset and gain calibration controller with per-channel trim registers.
`timescale 1ns/100ps
module adcogc_top #(
	parameter int CHANNELS  = 8,
	parameter bit GND_ROUTE = 1'b0
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Configuration
	input  wire logic [2:0]  wordRateSelect,
	input  wire logic [2:0]  inputRangeSelect,
	// Calibration command
	input  wire logic        calStart,
	input  wire adcogc_pkg::adcogc_cal_t calKind,
	input  wire logic [2:0]  calChannel,
	// Raw conversion stream
	input  wire logic        rawValid,
	input  wire logic [23:0] rawData,
	input  wire logic [2:0]  rawChannel,
	// Corrected result
	output logic             corrValid,
	output logic [23:0]      corrData,
	// Trim register access
	input  wire logic        trimWrite,
	input  wire logic        trimSelGain,
	input  wire logic [2:0]  trimChannel,
	input  wire logic [23:0] trimWdata,
	output logic [23:0]      trimRdata,
	// Analog routing and completion flag
	output adcogc_pkg::adcogc_route_t inputRoute,
	output logic             calBusy,
	output logic             serialDataOutput
);
	typedef struct packed {
		logic [CHANNELS-1:0][23:0] offs;
		logic [CHANNELS-1:0][23:0] gain;
		logic [15:0]               div;
		logic                      busy;
		logic                      armed;
		adcogc_pkg::adcogc_cal_t   kind;
		logic [2:0]                chan;
		logic [2:0]                range;
		logic                      corrV;
		logic [23:0]               corrD;
		logic [23:0]               rdata;
		logic                      serial_data_output;
		adcogc_pkg::adcogc_route_t route;
	} adcogc_state_t;

	adcogc_state_t st_r;
	adcogc_state_t st_nxt;
	adcogc_corr_if corr ();
	logic          rateTick;
	logic [15:0]   divLimit;
	logic [23:0]   gainCalc;
	logic [47:0]   gainWide;

	adcogc_correct uCorr (
		.corr (corr)
	);

	// The word rate code picks the conversion period; steps use it.
	assign divLimit = 16'(adcogc_pkg::RATE_DIV_BASE << wordRateSelect) - 16'h1;
	assign rateTick = (st_r.div == divLimit);

	always_comb begin
		corr.rawData    = rawData;
		corr.offsetTrim = st_r.offs[rawChannel];
		corr.gainTrim   = st_r.gain[rawChannel];
	end

	// Full scale target over the raw measured sample gives the new gain.
	always_comb begin
		gainWide = 48'h0;
		gainCalc = adcogc_pkg::GAIN_MAX;
		if (rawData[23] == 1'b0 && rawData != 24'h0) begin
			gainWide = ({24'h0, adcogc_pkg::GAIN_RST} << 23) / {24'h0, rawData};
			// Unrepresentable gain saturates to the top code.
			if (gainWide[47:24] == 24'h0) begin
				gainCalc = gainWide[23:0];
			end
		end
	end

	always_comb begin
		st_nxt       = st_r;
		st_nxt.corrV = 1'b0;
		st_nxt.div   = rateTick ? 16'h0 : st_r.div + 16'h1;
		if (trimWrite && !st_r.busy && trimChannel < CHANNELS) begin
			if (trimSelGain) begin
				st_nxt.gain[trimChannel] = trimWdata;
			end else begin
				st_nxt.offs[trimChannel] = trimWdata;
			end
		end
		if (trimChannel < CHANNELS) begin
			st_nxt.rdata = trimSelGain ? st_r.gain[trimChannel]
				: st_r.offs[trimChannel];
		end else begin
			st_nxt.rdata = 24'h0;
		end
		if (calStart && !st_r.busy && calChannel < CHANNELS) begin
			st_nxt.busy  = 1'b1;
			st_nxt.armed = 1'b0;
			st_nxt.kind  = calKind;
			st_nxt.chan  = calChannel;
			st_nxt.range = inputRangeSelect;
			st_nxt.div   = 16'h0;
			st_nxt.serial_data_output   = 1'b1;
			case (calKind)
				adcogc_pkg::ADCOGC_CAL_SELF_OFS: begin
					if (inputRangeSelect <= adcogc_pkg::RANGE_LOW_TOP) begin
						st_nxt.route = GND_ROUTE ?
							adcogc_pkg::ADCOGC_ROUTE_AMP_GND :
							adcogc_pkg::ADCOGC_ROUTE_AMP_NEG_IN;
					end else begin
						st_nxt.route = adcogc_pkg::ADCOGC_ROUTE_MOD_NEG_REF;
					end
				end
				// Amplifier is bypassed, so its gain stays uncorrected.
				adcogc_pkg::ADCOGC_CAL_SELF_GAIN:
					st_nxt.route = adcogc_pkg::ADCOGC_ROUTE_MOD_REF;
				default: st_nxt.route = adcogc_pkg::ADCOGC_ROUTE_NORMAL;
			endcase
		end else if (st_r.busy) begin
			// First tick starts the conversion, second ends it.
			if (rateTick && !st_r.armed) begin
				st_nxt.armed = 1'b1;
			end else if (rateTick && st_r.armed) begin
				st_nxt.busy  = 1'b0;
				st_nxt.serial_data_output   = 1'b0;
				st_nxt.route = adcogc_pkg::ADCOGC_ROUTE_NORMAL;
				case (st_r.kind)
					adcogc_pkg::ADCOGC_CAL_SELF_OFS,
					adcogc_pkg::ADCOGC_CAL_SYS_OFS:
						st_nxt.offs[st_r.chan] = 24'(-rawData);
					default:
						st_nxt.gain[st_r.chan] = gainCalc;
				endcase
			end
		end else if (rawValid && rawChannel < CHANNELS) begin
			st_nxt.corrV = 1'b1;
			st_nxt.corrD = corr.corrData;
		end
		if (!resetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				st_nxt.offs[i] = adcogc_pkg::OFFSET_RST;
				st_nxt.gain[i] = adcogc_pkg::GAIN_RST;
			end
			st_nxt.div   = 16'h0;
			st_nxt.busy  = 1'b0;
			st_nxt.armed = 1'b0;
			st_nxt.kind  = adcogc_pkg::ADCOGC_CAL_SELF_OFS;
			st_nxt.chan  = 3'h0;
			st_nxt.range = 3'h0;
			st_nxt.corrV = 1'b0;
			st_nxt.corrD = 24'h0;
			st_nxt.rdata = 24'h0;
			st_nxt.serial_data_output   = 1'b1;
			st_nxt.route = adcogc_pkg::ADCOGC_ROUTE_NORMAL;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_r <= st_nxt;
	end

	assign corrValid        = st_r.corrV;
	assign corrData         = st_r.corrD;
	assign trimRdata        = st_r.rdata;
	assign inputRoute       = st_r.route;
	assign calBusy          = st_r.busy;
	assign serialDataOutput = st_r.serial_data_output;

	gain_reset_a: assert property (@(posedge sys_clk)
		!resetn |=> st_r.gain[0] == 24'h400000)
		else $error("gain not unity after reset");
	offset_reset_a: assert property (@(posedge sys_clk)
		!resetn |=> st_r.offs[0] == 24'h000000)
		else $error("offset not zero after reset");
	sequence calStartS;
		calStart && !calBusy && calChannel < CHANNELS && resetn;
	endsequence
	step_flag_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		calStartS |=> serialDataOutput && calBusy)
		else $error("step did not raise busy flag");
	step_end_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		$fell(calBusy) |-> !serialDataOutput)
		else $error("flag not low at step end");
	step_rate_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		$fell(calBusy) |-> $past(rateTick))
		else $error("step ended off word rate");
	// The low ranges must land on the amplifier short of this variant.
	route_low_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		calStartS and (calKind == adcogc_pkg::ADCOGC_CAL_SELF_OFS &&
		inputRangeSelect <= 3'h2) |=>
		inputRoute == (GND_ROUTE ? adcogc_pkg::ADCOGC_ROUTE_AMP_GND :
		adcogc_pkg::ADCOGC_ROUTE_AMP_NEG_IN))
		else $error("low range offset routing wrong");
	route_high_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		calStartS and (calKind == adcogc_pkg::ADCOGC_CAL_SELF_OFS &&
		inputRangeSelect > 3'h2) |=>
		inputRoute == adcogc_pkg::ADCOGC_ROUTE_MOD_NEG_REF)
		else $error("high range offset routing wrong");
	route_gain_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		calStartS and (calKind == adcogc_pkg::ADCOGC_CAL_SELF_GAIN) |=>
		inputRoute == adcogc_pkg::ADCOGC_ROUTE_MOD_REF)
		else $error("self gain routing wrong");
	trim_write_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		trimWrite && !calBusy && !calStart && !trimSelGain &&
		trimChannel == 3'h0 |=> st_r.offs[0] == $past(trimWdata))
		else $error("offset restore lost");
	other_chan_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		$fell(calBusy) && st_r.chan != 3'h0 && !$past(trimWrite) |->
		$stable(st_r.gain[0]) && $stable(st_r.offs[0]))
		else $error("other channel trim changed");
	unity_pass_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		rawValid && !calBusy && !calStart && rawChannel < CHANNELS &&
		corr.gainTrim == 24'h400000 && corr.offsetTrim == 24'h0 |=>
		corrValid && corrData == $past(rawData))
		else $error("unity correction altered data");
endmodule

//--- src/adcogc_pkg.sv
// Shared constants and types of the offset and gain calibration block.
package adcogc_pkg;
	localparam int           WORD_W       = 24;
	localparam int           CHAN_W       = 3;
	localparam int           GAIN_FRAC    = 22;
	localparam logic [23:0]  OFFSET_RST   = 24'h000000;
	localparam logic [23:0]  GAIN_RST     = 24'h400000;
	localparam logic [23:0]  GAIN_MAX     = 24'hffffff;
	localparam int           RATE_W       = 3;
	localparam int           RANGE_W      = 3;
	// Input ranges 0..2 are the low (amplifier) ranges, 3..7 the high ones.
	localparam logic [2:0]   RANGE_LOW_TOP = 3'h2;
	// Master clock cycles per output word at word rate code 0; each code step doubles it.
	localparam int           RATE_DIV_BASE = 64;

	typedef enum logic [2:0] {
		ADCOGC_CAL_SELF_OFS,
		ADCOGC_CAL_SELF_GAIN,
		ADCOGC_CAL_SYS_OFS,
		ADCOGC_CAL_SYS_GAIN
	} adcogc_cal_t;

	typedef enum logic [2:0] {
		ADCOGC_ROUTE_NORMAL,
		ADCOGC_ROUTE_AMP_NEG_IN,
		ADCOGC_ROUTE_AMP_GND,
		ADCOGC_ROUTE_MOD_NEG_REF,
		ADCOGC_ROUTE_MOD_REF
	} adcogc_route_t;
endpackage

//--- src/adcogc_corr_if.sv
// Carrier between the controller and the correction datapath.
`timescale 1ns/100ps
interface adcogc_corr_if;
	logic [23:0] rawData;
	logic [23:0] offsetTrim;
	logic [23:0] gainTrim;
	logic [23:0] corrData;
	modport ctrl (output rawData, output offsetTrim, output gainTrim,
		input corrData);
	modport dp (input rawData, input offsetTrim, input gainTrim,
		output corrData);
endinterface

//--- src/adcogc_correct.sv
// Correction datapath: (raw + offset) * gain / 2^22, saturated.
`timescale 1ns/100ps
module adcogc_correct (
	// Carrier
	adcogc_corr_if.dp corr
);
	logic signed [25:0] sumVal;
	logic signed [51:0] prodVal;
	logic signed [29:0] scaled;

	always_comb begin
		// Offset is two's complement; its top bit is the sign.
		sumVal  = 26'(signed'(corr.rawData)) + 26'(signed'(corr.offsetTrim));
		// Gain is unsigned, top bit weight two, 22 fraction bits.
		prodVal = 52'(sumVal) * signed'({28'h0, corr.gainTrim});
		scaled  = 30'(prodVal >>> adcogc_pkg::GAIN_FRAC);
		if (scaled > 30'sh7fffff) begin
			corr.corrData = 24'h7fffff;
		end else if (scaled < -30'sh800000) begin
			corr.corrData = 24'h800000;
		end else begin
			corr.corrData = scaled[23:0];
		end
	end
endmodule

//--- tb/adcogc_host.sv
// Host model that drives calibration commands and trim accesses.
`timescale 1ns/100ps
module adcogc_host (
	// Clock and status
	input  wire logic                      sys_clk,
	input  wire logic                      serialDataOutput,
	input  wire adcogc_pkg::adcogc_route_t inputRoute,
	// Calibration command
	output logic                           calStart,
	output adcogc_pkg::adcogc_cal_t        calKind,
	output logic [2:0]                     calChannel,
	output logic [2:0]                     wordRateSelect,
	output logic [2:0]                     inputRangeSelect,
	// Trim access
	output logic                           trimWrite,
	output logic                           trimSelGain,
	output logic [2:0]                     trimChannel,
	output logic [23:0]                    trimWdata
);
	initial begin
		calStart = 1'b0;
		calKind = adcogc_pkg::ADCOGC_CAL_SELF_OFS;
		calChannel = 3'h0;
		wordRateSelect = 3'h0;
		inputRangeSelect = 3'h0;
		trimWrite = 1'b0;
		trimSelGain = 1'b0;
		trimChannel = 3'h0;
		trimWdata = 24'h000000;
	end
	task automatic trim_wr(input logic g, input logic [2:0] ch,
		input logic [23:0] d);
		@(negedge sys_clk);
		trimWrite = 1'b1;
		trimSelGain = g;
		trimChannel = ch;
		trimWdata = d;
		@(negedge sys_clk);
		trimWrite = 1'b0;
	endtask
	task automatic trim_rd(input logic g, input logic [2:0] ch);
		@(negedge sys_clk);
		trimSelGain = g;
		trimChannel = ch;
		repeat (2) @(negedge sys_clk);
	endtask
	// The cal task waits until the step has ended, giving up after 600 cycles.
	task automatic cal(input adcogc_pkg::adcogc_cal_t k,
		input logic [2:0] ch, input logic [2:0] rng, input logic [2:0] wr,
		output int n, output adcogc_pkg::adcogc_route_t rt);
		@(negedge sys_clk);
		calStart = 1'b1;
		calKind = k;
		calChannel = ch;
		inputRangeSelect = rng;
		wordRateSelect = wr;
		@(negedge sys_clk);
		calStart = 1'b0;
		rt = inputRoute;
		n = 0;
		while (serialDataOutput !== 1'b0 && n < 600) begin
			@(negedge sys_clk);
			n++;
		end
	endtask
endmodule

//--- tb/test_adc_offset_gain_calibration.sv
// Self-checking bench of the offset and gain calibration block.
`timescale 1ns/100ps
module test_adc_offset_gain_calibration;
	logic                      sys_clk = 1'b0;
	logic                      resetn = 1'b0;
	logic                      rawValid = 1'b0;
	logic [23:0]               rawData = 24'h000000;
	logic [2:0]                rawChannel = 3'h0;
	logic                      calStart, trimWrite, trimSelGain;
	logic                      corrValid, calBusy, serial_data_output;
	adcogc_pkg::adcogc_cal_t   calKind;
	adcogc_pkg::adcogc_route_t route, rt;
	logic [2:0]                calChannel, wrSel, rngSel, trimChannel;
	logic [23:0]               trimWdata, trimRdata, corrData;
	int                        badCount = 0;
	int                        nChecks = 0;
	int                        n;

	always #20 sys_clk = ~sys_clk;

	adcogc_top #(.CHANNELS(6), .GND_ROUTE(1'b0)) dut (.sys_clk(sys_clk),
		.resetn(resetn), .wordRateSelect(wrSel), .inputRangeSelect(rngSel),
		.calStart(calStart), .calKind(calKind), .calChannel(calChannel),
		.rawValid(rawValid), .rawData(rawData), .rawChannel(rawChannel),
		.corrValid(corrValid), .corrData(corrData), .trimWrite(trimWrite),
		.trimSelGain(trimSelGain), .trimChannel(trimChannel),
		.trimWdata(trimWdata), .trimRdata(trimRdata), .inputRoute(route),
		.calBusy(calBusy), .serialDataOutput(serial_data_output));
	adcogc_host host (.sys_clk(sys_clk), .serialDataOutput(serial_data_output),
		.inputRoute(route), .calStart(calStart), .calKind(calKind),
		.calChannel(calChannel), .wordRateSelect(wrSel),
		.inputRangeSelect(rngSel), .trimWrite(trimWrite),
		.trimSelGain(trimSelGain), .trimChannel(trimChannel),
		.trimWdata(trimWdata));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stopTest();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic conv(input logic [2:0] ch, input logic [23:0] d,
		input logic [23:0] exp);
		@(negedge sys_clk);
		rawValid = 1'b1;
		rawChannel = ch;
		rawData = d;
		@(negedge sys_clk);
		rawValid = 1'b0;
		chk({23'h0, corrValid}, 24'h000001);
		chk(corrData, exp);
	endtask
	task automatic rd(input logic g, input logic [2:0] ch,
		input logic [23:0] exp);
		host.trim_rd(g, ch);
		chk(trimRdata, exp);
	endtask
	// The step must end between one and two word periods after its start.
	task automatic calib(input adcogc_pkg::adcogc_cal_t k,
		input logic [2:0] ch, input logic [2:0] rng, input logic [2:0] wr,
		input logic [23:0] smp, input adcogc_pkg::adcogc_route_t er);
		rawData = smp;
		host.cal(k, ch, rng, wr, n, rt);
		chk({21'h0, rt}, {21'h0, er});
		chk({23'h0, n > (64 << wr) && n <= (128 << wr)}, 24'h000001);
		chk({23'h0, calBusy}, 24'h000000);
		if (n >= 600) begin
			badCount++;
			stopTest();
		end
	endtask

	initial begin
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		rd(1'b0, 3'h1, 24'h000000);
		rd(1'b1, 3'h1, 24'h400000);
		chk({23'h0, serial_data_output}, 24'h000001);
		conv(3'h0, 24'h001234, 24'h001234);
		$display("test reset done");
		host.trim_wr(1'b0, 3'h0, 24'h000010);
		host.trim_wr(1'b1, 3'h0, 24'h800000);
		rd(1'b1, 3'h0, 24'h800000);
		conv(3'h0, 24'h001234, 24'h002488);
		host.trim_wr(1'b0, 3'h0, 24'hfffff0);
		conv(3'h0, 24'h001234, 24'h002448);
		conv(3'h0, 24'h7ff000, 24'h7fffff);
		conv(3'h1, 24'hfff000, 24'hfff000);
		rd(1'b1, 3'h6, 24'h000000);
		$display("test correction done");
		calib(adcogc_pkg::ADCOGC_CAL_SELF_OFS, 3'h2, 3'h0, 3'h0, 24'h000020,
			adcogc_pkg::ADCOGC_ROUTE_AMP_NEG_IN);
		chk({23'h0, serial_data_output}, 24'h000000);
		rd(1'b0, 3'h2, 24'hffffe0);
		rd(1'b0, 3'h0, 24'hfffff0);
		calib(adcogc_pkg::ADCOGC_CAL_SELF_OFS, 3'h3, 3'h3, 3'h1, 24'h000020,
			adcogc_pkg::ADCOGC_ROUTE_MOD_NEG_REF);
		calib(adcogc_pkg::ADCOGC_CAL_SELF_GAIN, 3'h3, 3'h0, 3'h0, 24'h400000,
			adcogc_pkg::ADCOGC_ROUTE_MOD_REF);
		rd(1'b1, 3'h3, 24'h800000);
		calib(adcogc_pkg::ADCOGC_CAL_SYS_GAIN, 3'h4, 3'h4, 3'h0, 24'h100000,
			adcogc_pkg::ADCOGC_ROUTE_NORMAL);
		rd(1'b1, 3'h4, 24'hffffff);
		fork
			calib(adcogc_pkg::ADCOGC_CAL_SYS_OFS, 3'h5, 3'h5, 3'h0,
				24'hfffff8, adcogc_pkg::ADCOGC_ROUTE_NORMAL);
			begin
				repeat (10) @(negedge sys_clk);
				chk({23'h0, calBusy}, 24'h000001);
				host.trim_wr(1'b1, 3'h5, 24'h123456);
			end
		join
		rd(1'b0, 3'h5, 24'h000008);
		rd(1'b1, 3'h5, 24'h400000);
		$display("test calibration done");
		stopTest();
	end
endmodule
